/* File: rtl/adcsp_defines.svh */
// Constants for the serial conversion port: control fields, counts and timing
//
// Functional notes
// R01: Serial clock converts and shifts frame data
// R02: Select fall holds, samples, drives output, converts
// R03: Conversion needs sixteen serial clocks per frame
// R04: Track resumes on fourteenth falling edge
// R05: Shadow-write frame holds until select rises
// R06: Output released on sixteenth falling edge
// R07: Early select rise aborts, control kept
// R08: Word is zero, address, twelve result bits
// R09: Zero at select fall, then msb first
// R10: Last bit out on fifteenth edge
// R11: Write flag set loads twelve control bits
// R12: Armed shadow takes all sixteen input bits
// R13: Host zeros low byte for single sequence
// R14: Shadow loads, then first sequence channel tracks
// R15: Host spaces valid conversions five microseconds apart
// R16: Host may convert soon after power-up write
// R17: Output stays undriven in shutdown write frame
// R18: Every select fall advances an active sequence
// R19: Host sends two all-ones frames after power-up
// R20: Auto shutdown sleeps after conversion, wakes on select
// R21: Host holds select for exactly sixteen clocks
`ifndef ADCSP_DEFINES_SVH
`define ADCSP_DEFINES_SVH

// Frame geometry
`define ADCSP_FRAME_BITS 16
`define ADCSP_CTRL_BITS 12
`define ADCSP_TRACK_EDGE 5'd14
`define ADCSP_LAST_EDGE 5'd16

// Control register field positions (12-bit register)
`define ADCSP_CTRL_WRITE 11
`define ADCSP_CTRL_SEQ 10
`define ADCSP_CTRL_ADDR_HI 8
`define ADCSP_CTRL_ADDR_LO 6
`define ADCSP_CTRL_PM_HI 5
`define ADCSP_CTRL_PM_LO 4
`define ADCSP_CTRL_SHADOW 3
`define ADCSP_CTRL_RESET 12'h030

// Power mode codes
`define ADCSP_PM_NORMAL 2'h3
`define ADCSP_PM_FULL 2'h2
`define ADCSP_PM_AUTO 2'h1

// Host timing
`define ADCSP_MCLK_NS 8
`define ADCSP_SPACING_NS 5000
`define ADCSP_SPACING_CYC ((`ADCSP_SPACING_NS + `ADCSP_MCLK_NS - 1) / `ADCSP_MCLK_NS)
`define ADCSP_HALF_CYC 4

`endif

/* File: rtl/adcsp_pkg.sv */
// Types for the serial conversion port: channel for the converter end, word and state for the host end
package adcsp_pkg;
  typedef logic [2:0] adcsp_chan_t;
  typedef logic [15:0] adcsp_word_t;
  typedef enum logic [3:0] {
    HST_IDLE = 4'b0001,
    HST_LEAD = 4'b0010,
    HST_LOW = 4'b0100,
    HST_HIGH = 4'b1000
  } adcsp_hstate_e;
endpackage

/* File: rtl/adcsp_link_if.sv */
// Link wires between host and converter ends
`timescale 1ns/100ps
interface adcsp_link_if;
  logic csN;
  logic sclk;
  logic din;
  logic doutO;
  logic doutOe;
  logic dout;
  // Released data line reads high through a pull-up
  assign dout = doutOe ? doutO : 1'b1;
  modport dev (input csN, input sclk, input din, output doutO, output doutOe);
  modport host (output csN, output sclk, output din, input dout);
endinterface

/* File: rtl/adcsp_device.sv */
// Converter end: frame shifter, control and shadow registers, sequencer
`timescale 1ns/100ps
`include "adcsp_defines.svh"
module adcsp_device (
  adcsp_link_if.dev lnk, // Serial link
  input wire logic rst, // Reset, sampled on serial clock falls
  input wire logic [11:0] convData, // Result from converter core
  output adcsp_pkg::adcsp_chan_t convChan, // Channel under the mux
  output logic trackHold, // High while in hold
  output logic powerDown, // High while powered down
  output logic [11:0] ctrlView, // Control register contents
  output logic seqActive // Sequence running
);
  import adcsp_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Next set bit of a channel mask after the current channel
  function automatic adcsp_chan_t nextChan(input logic [7:0] mask, input adcsp_chan_t cur);
    adcsp_chan_t r;
    adcsp_chan_t c;
    logic found;
    r = cur;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      c = 3'(int'(cur) + i);
      if (!found && mask[c]) begin
        r = c;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  logic [1:0] rstSync_q;
  logic [4:0] bitCnt_q;
  logic [15:0] outSh_q;
  logic [14:0] inSh_q;
  logic [11:0] ctrl_q;
  logic [7:0] seqMask_q;
  logic seqOn_q;
  logic shadowArm_q;
  logic autoDown_q;
  logic shadowHold_q;
  adcsp_chan_t mux_q;

  ////////////////////////////////////////////////////////////////
  // Reset crosses into the link domain; only the second flop is used
  always_ff @(negedge lnk.sclk) begin
    rstSync_q <= {rstSync_q[0], rst};
  end
  wire rstL = rstSync_q[1];

  // Frame position decode
  wire firstEdge = (bitCnt_q == 5'd0);
  wire lastEdge = (bitCnt_q == `ADCSP_LAST_EDGE - 5'd1);
  wire frameDone = (bitCnt_q == `ADCSP_LAST_EDGE);
  wire [15:0] inWord = {inSh_q, lnk.din};
  wire [1:0] pmNow = ctrl_q[`ADCSP_CTRL_PM_HI:`ADCSP_CTRL_PM_LO];
  wire fullDown = (pmNow == `ADCSP_PM_FULL);
  wire [11:0] ctrlNew = inWord[15:4];
  wire [2:0] addrNew = ctrlNew[`ADCSP_CTRL_ADDR_HI:`ADCSP_CTRL_ADDR_LO];
  wire [1:0] pmNew = ctrlNew[`ADCSP_CTRL_PM_HI:`ADCSP_CTRL_PM_LO];
  wire [1:0] modeNew = {ctrlNew[`ADCSP_CTRL_SEQ], ctrlNew[`ADCSP_CTRL_SHADOW]};
  wire ctrlWrite = lastEdge && inWord[15] && !shadowArm_q; // R11
  wire shadowLoad = lastEdge && shadowArm_q; // R12
  wire [7:0] shadowMask = inWord[15:8] | inWord[7:0]; // R13
  wire [7:0] lowMask = 8'hFF >> (3'd7 - addrNew);

  ////////////////////////////////////////////////////////////////
  // Edge counter; select rising clears it, so a short frame never commits
  always_ff @(negedge lnk.sclk or posedge lnk.csN) begin
    if (lnk.csN) begin
      bitCnt_q <= 5'd0; // R07
    end else if (!frameDone) begin
      bitCnt_q <= bitCnt_q + 5'd1; // R01 R03
    end
  end

  // Output shifter: cleared to the leading zero while select is high
  always_ff @(negedge lnk.sclk or posedge lnk.csN) begin
    if (lnk.csN) begin
      outSh_q <= 16'h0000; // R09
    end else if (firstEdge) begin
      outSh_q <= {mux_q, convData, 1'b0}; // R08 R09
    end else begin
      outSh_q <= {outSh_q[14:0], 1'b0}; // R10
    end
  end

  // Input shifter, one bit per falling edge
  always_ff @(negedge lnk.sclk) begin
    inSh_q <= inWord[14:0];
  end

  ////////////////////////////////////////////////////////////////
  // Control register; only a complete write frame reaches it
  always_ff @(negedge lnk.sclk) begin
    if (rstL) begin
      ctrl_q <= `ADCSP_CTRL_RESET;
    end else if (ctrlWrite) begin
      ctrl_q <= ctrlNew; // R11
    end
  end

  // Shadow arming: set by a control write that asks for it
  always_ff @(negedge lnk.sclk) begin
    if (rstL) begin
      shadowArm_q <= 1'b0;
    end else if (shadowLoad) begin
      shadowArm_q <= 1'b0;
    end else if (ctrlWrite) begin
      shadowArm_q <= (modeNew == 2'b01); // R12
    end
  end

  // Sequencer mask and running flag
  always_ff @(negedge lnk.sclk) begin
    if (rstL) begin
      seqMask_q <= 8'h00;
      seqOn_q <= 1'b0;
    end else if (shadowLoad) begin
      seqMask_q <= shadowMask; // R14
      seqOn_q <= (shadowMask != 8'h00);
    end else if (ctrlWrite && modeNew == 2'b11) begin
      seqMask_q <= lowMask;
      seqOn_q <= 1'b1;
    end else if (ctrlWrite && modeNew != 2'b10) begin
      seqOn_q <= 1'b0;
    end
  end

  // Mux channel; a running sequence steps on every frame start
  always_ff @(negedge lnk.sclk) begin
    if (rstL) begin
      mux_q <= 3'h0;
    end else if (shadowLoad) begin
      mux_q <= nextChan(shadowMask, 3'h7); // R14
    end else if (ctrlWrite && modeNew == 2'b11) begin
      mux_q <= 3'h0;
    end else if (ctrlWrite && modeNew == 2'b00) begin
      mux_q <= addrNew;
    end else if (firstEdge && seqOn_q) begin
      mux_q <= nextChan(seqMask_q, mux_q); // R18
    end
  end

  // Shadow frame commits at the last fall but must stay in hold until select rises
  always_ff @(negedge lnk.sclk or posedge lnk.csN) begin
    if (lnk.csN) begin
      shadowHold_q <= 1'b0;
    end else if (shadowLoad) begin
      shadowHold_q <= 1'b1; // R05
    end
  end

  // Auto shutdown: sleep after the conversion, wake on the next frame
  always_ff @(negedge lnk.sclk) begin
    if (rstL) begin
      autoDown_q <= 1'b0;
    end else if (lastEdge) begin
      autoDown_q <= ((ctrlWrite ? pmNew : pmNow) == `ADCSP_PM_AUTO); // R20
    end else if (firstEdge) begin
      autoDown_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin and status outputs; select low takes effect without a clock edge
  assign lnk.doutO = outSh_q[15];
  assign lnk.doutOe = !lnk.csN && !frameDone && !fullDown; // R02 R06 R07 R17
  assign powerDown = fullDown || (autoDown_q && lnk.csN); // R20
  // Arming frame sets the flag at its last fall; it must not hold that frame
  wire shadowHeld = (shadowArm_q && !frameDone) || shadowHold_q;
  assign trackHold = powerDown || (!lnk.csN && (bitCnt_q < `ADCSP_TRACK_EDGE || shadowHeld)); // R02 R04 R05
  assign convChan = mux_q;
  assign ctrlView = ctrl_q;
  assign seqActive = seqOn_q;
endmodule // adcsp_device

/* File: rtl/adcsp_host.sv */
// Host end: frame generator with divided serial clock
`timescale 1ns/100ps
`include "adcsp_defines.svh"
module adcsp_host (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  adcsp_link_if.host lnk, // Serial link
  input wire logic start, // Request a frame
  input wire adcsp_pkg::adcsp_word_t txWord, // Word sent to the converter
  output logic busy, // Frame in progress
  output adcsp_pkg::adcsp_word_t rxWord, // Last word received
  output logic rxValid // One-cycle pulse with rxWord
);
  import adcsp_pkg::*;

  localparam logic [9:0] SPACE_CYC = 10'(`ADCSP_SPACING_CYC);
  localparam logic [2:0] HALF_CYC = 3'(`ADCSP_HALF_CYC);

  adcsp_hstate_e state_q;
  logic [2:0] halfCnt_q;
  logic [4:0] fallCnt_q;
  logic [9:0] spaceCnt_q;
  logic [15:0] txSh_q;
  logic [15:0] rxSh_q;
  logic [1:0] doutS_q;
  logic csN_q;
  logic sclk_q;
  logic din_q;
  logic busy_q;
  logic rxValid_q;
  logic [15:0] rxWord_q;

  wire halfDone = (halfCnt_q == HALF_CYC - 3'd1);
  wire canStart = start && (spaceCnt_q == 10'd0); // R15 R16
  wire [15:0] rxNext = {rxSh_q[14:0], doutS_q[1]};

  ////////////////////////////////////////////////////////////////
  // Data line crosses two flops before it is sampled
  always_ff @(posedge mclk) begin
    doutS_q <= {doutS_q[0], lnk.dout};
  end

  // Half-period divider for the serial clock
  always_ff @(posedge mclk) begin
    if (rst || state_q == HST_IDLE || halfDone) begin
      halfCnt_q <= 3'd0;
    end else begin
      halfCnt_q <= halfCnt_q + 3'd1;
    end
  end

  // Conversion spacing, counted from each select fall
  always_ff @(posedge mclk) begin
    if (rst) begin
      spaceCnt_q <= 10'd0;
    end else if (state_q == HST_IDLE && canStart) begin
      spaceCnt_q <= SPACE_CYC - 10'd1; // R15
    end else if (spaceCnt_q != 10'd0) begin
      spaceCnt_q <= spaceCnt_q - 10'd1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Frame sequencer: select low for exactly sixteen serial clocks
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= HST_IDLE;
      csN_q <= 1'b1;
      sclk_q <= 1'b1;
      din_q <= 1'b1;
      busy_q <= 1'b0;
      rxValid_q <= 1'b0;
      rxWord_q <= 16'h0000;
      fallCnt_q <= 5'd0;
      txSh_q <= 16'h0000;
      rxSh_q <= 16'h0000;
    end else begin
      rxValid_q <= 1'b0;
      case (state_q)
        HST_IDLE: begin
          if (canStart) begin
            csN_q <= 1'b0;
            txSh_q <= txWord;
            din_q <= txWord[15]; // R21
            busy_q <= 1'b1;
            fallCnt_q <= 5'd0;
            state_q <= HST_LEAD;
          end
        end
        HST_LEAD: begin
          if (halfDone) begin
            rxSh_q <= rxNext;
            sclk_q <= 1'b0;
            fallCnt_q <= 5'd1;
            state_q <= HST_LOW;
          end
        end
        HST_LOW: begin
          if (halfDone) begin
            sclk_q <= 1'b1;
            if (fallCnt_q == `ADCSP_LAST_EDGE) begin
              csN_q <= 1'b1; // R03 R21
              busy_q <= 1'b0;
              rxWord_q <= rxSh_q;
              rxValid_q <= 1'b1;
              state_q <= HST_IDLE;
            end else begin
              txSh_q <= {txSh_q[14:0], 1'b0};
              din_q <= txSh_q[14]; // R21
              state_q <= HST_HIGH;
            end
          end
        end
        HST_HIGH: begin
          if (halfDone) begin
            rxSh_q <= rxNext;
            sclk_q <= 1'b0;
            fallCnt_q <= fallCnt_q + 5'd1;
            state_q <= HST_LOW;
          end
        end
        default: begin
          state_q <= HST_IDLE;
        end
      endcase
    end
  end

  assign lnk.csN = csN_q;
  assign lnk.sclk = sclk_q;
  assign lnk.din = din_q;
  assign busy = busy_q;
  assign rxWord = rxWord_q;
  assign rxValid = rxValid_q;
endmodule // adcsp_host

/* File: dv/adcsp_link_monitor.sv */
// Protocol checker on the serial link wires
`timescale 1ns/100ps
module adcsp_link_monitor (
  input wire logic mclk, // Host clock
  input wire logic rst, // Converter reset
  input wire logic csN, // Select
  input wire logic sclk, // Serial clock
  input wire logic din, // Host data
  input wire logic doutO, // Device data
  input wire logic doutOe, // Device enable
  input wire logic dout // Resolved line
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic [4:0] fallCnt_q;
  logic [9:0] gapCnt_q;
  ////////////////////////////////////////
  // Falls within a frame; cleared while deselected
  always_ff @(posedge mclk) begin
    if (rst || csN) fallCnt_q <= 5'h00;
    else if ($fell(sclk)) fallCnt_q <= fallCnt_q + 5'h01;
  end
  // Cycles since last select fall, saturating so idle time never wraps
  always_ff @(posedge mclk) begin
    if (rst) gapCnt_q <= 10'h3FF;
    else if ($fell(csN)) gapCnt_q <= 10'h001;
    else if (gapCnt_q != 10'h3FF) gapCnt_q <= gapCnt_q + 10'h001;
  end
  ////////////////////////////////////////
  // Low phase of the divided clock, then back high
  sequence lowHalf;
    !sclk [*4] ##1 sclk;
  endsequence
  // Leading zero on both the flop and the wire
  sequence leadOut;
    !doutO && !dout;
  endsequence
  a_half_period: assert property ($fell(sclk) |-> lowHalf)
    else $error("serial clock low phase is not four cycles");
  a_lead_zero: assert property ($rose(doutOe) |-> leadOut and $fell(csN))
    else $error("output not opened with a zero at select fall");
  a_drive_selected: assert property (doutOe |-> !csN)
    else $error("output driven while deselected");
  a_release_last: assert property (fallCnt_q == 5'h10 |-> !doutOe)
    else $error("output still driven after sixteenth fall");
  a_frame_count: assert property ($rose(csN) |-> fallCnt_q == 5'h10)
    else $error("frame did not carry sixteen clocks");
  a_bit_timing: assert property ($changed(doutO) && doutOe && $past(doutOe) |-> $fell(sclk))
    else $error("output bit moved off a falling edge");
  a_din_timing: assert property ($changed(din) && !csN && !$fell(csN) |-> $rose(sclk))
    else $error("input bit moved off a rising edge");
  a_sclk_idle: assert property (csN |-> sclk)
    else $error("serial clock low outside a frame");
  a_frame_spacing: assert property ($fell(csN) |-> gapCnt_q >= 10'd625)
    else $error("select falls closer than five microseconds");
endmodule // adcsp_link_monitor

/* File: dv/test_adc_serial_conversion_port.sv */
// Self-checking bench: host and converter joined over the link
`timescale 1ns/100ps
module test_adc_serial_conversion_port;
  import adcsp_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, devRst = 1'b1, start = 1'b0, expLate = 1'b0, expEnd = 1'b0;
  logic busy, rxValid, trackHold, powerDown, seqActive;
  adcsp_word_t txWord = 16'h0000, rxWord, junk;
  logic [11:0] convData = 12'h000, ctrlView, ctrl = 12'h030;
  int error_cnt = 0, check_count = 0, seed = 25444, mux = 0, seqLast = 0, i;
  bit seqOn = 1'b0, arm = 1'b0;
  adcsp_link_if lnk();
  adcsp_host i_adcsp_host (.mclk(mclk), .rst(rst), .lnk(lnk), .start(start), .txWord(txWord),
    .busy(busy), .rxWord(rxWord), .rxValid(rxValid));
  adcsp_device i_adcsp_device (.lnk(lnk), .rst(devRst), .convData(convData), .convChan(),
    .trackHold(trackHold), .powerDown(powerDown), .ctrlView(ctrlView), .seqActive(seqActive));
  adcsp_link_monitor i_adcsp_link_monitor (.mclk(mclk), .rst(devRst), .csN(lnk.csN), .sclk(lnk.sclk),
    .din(lnk.din), .doutO(lnk.doutO), .doutOe(lnk.doutOe), .dout(lnk.dout));
  ////////////////////////////////////////
  // System clock, 8 ns
  initial begin
    forever #4 mclk = ~mclk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  // One host frame; start held until taken, since spacing may refuse it
  task automatic frame(input adcsp_word_t tx, output adcsp_word_t rx);
    int n;
    txWord = tx;
    start = 1'b1;
    fork
      begin
        @(negedge lnk.csN);
        #1 check(trackHold, 1'b1);
        repeat (14) @(negedge lnk.sclk);
        #1 check(trackHold, expLate);
        repeat (2) @(negedge lnk.sclk);
        #1 check(trackHold, expEnd);
      end
    join_none
    for (n = 0; n < 1000 && busy !== 1'b1; n++) @(negedge mclk);
    start = 1'b0;
    for (n = 0; n < 1000 && rxValid !== 1'b1; n++) @(negedge mclk);
    check(rxValid, 1'b1);
    rx = rxWord;
  endtask
  // Predict one frame's answer, compare, then advance the model
  task automatic run(input adcsp_word_t tx);
    adcsp_word_t rx;
    logic [11:0] dat;
    bit dark, shadowFrame;
    dat = 12'($random(seed));
    dark = (ctrl[5:4] == 2'h2);
    shadowFrame = arm;
    convData = dat;
    // Full shutdown keeps hold until the commit; shadow frames hold to select rise
    expLate = shadowFrame || dark;
    expEnd = shadowFrame || ((tx[15] && !shadowFrame) ? tx[9:8] : ctrl[5:4]) == 2'h2;
    frame(tx, rx);
    if (dark) check(rx, 16'hFFFF);
    else if (!shadowFrame) check(rx, {1'b0, 3'(mux), dat});
    if (shadowFrame) begin
      seqOn = 1'b1;
      seqLast = 7;
      mux = 0;
    end else if (tx[15]) begin
      ctrl = tx[15:4];
      seqOn = ctrl[10] & ctrl[3];
      seqLast = ctrl[8:6];
      mux = seqOn ? 0 : ctrl[8:6];
    end else if (seqOn) begin
      mux = (mux == seqLast) ? 0 : mux + 1;
    end
    arm = !shadowFrame && tx[15] && ctrl[3] && !ctrl[10];
    check(ctrlView, ctrl);
    check(powerDown, ctrl[5:4] inside {2'h1, 2'h2});
    check(seqActive, seqOn);
  endtask
  ////////////////////////////////////////
  // Main sequence; converter reset spans a whole frame as its sync needs
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    frame(16'hFFFF, junk);
    // Checker stays off until the frame that clears converter state has ended
    repeat (2) @(negedge mclk);
    devRst = 1'b0;
    run(16'hFFFF);
    for (i = 0; i < 8; i++) run({3'b100, 3'(i), 2'h3, 1'b0, 7'($random(seed))});
    run({3'b110, 3'h2, 2'h3, 1'b1, 7'h00});
    repeat (4) run({1'b0, 15'($random(seed))});
    run({3'b100, 3'h0, 2'h3, 1'b1, 7'h00});
    run(16'hFF00);
    repeat (3) run({1'b0, 15'($random(seed))});
    run({3'b100, 3'h5, 2'h1, 1'b0, 7'h00});
    run({1'b0, 15'($random(seed))});
    run({3'b100, 3'h3, 2'h2, 1'b0, 7'h00});
    run({3'b100, 3'h3, 2'h3, 1'b0, 7'h00});
    run({1'b0, 15'($random(seed))});
    test_done();
  end
  // Watchdog: 25 frames spaced 625 cycles apart fit well inside
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    test_done();
  end
endmodule // test_adc_serial_conversion_port
